// ===== cam_match_block.sv
`default_nettype none

module cam_match_block #(
  // Configuration preload, one entry per word
  parameter logic [31:0] init_data  [32] = '{default: cam_match_pkg::DATA_RST},
  parameter logic [31:0] init_care  [32] = '{default: cam_match_pkg::CARE_ALL},
  parameter logic [31:0] init_valid      = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Word write request
  input  wire logic        wr_req_in,
  input  wire logic [4:0]  wr_addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [31:0] wr_care_in,
  input  wire logic        wr_mask_in,
  // Search request
  input  wire logic        search_req_in,
  input  wire logic [31:0] search_data_in,
  input  wire logic        encoded_in,
  // Status
  output logic             busy_out,
  // Encoded result
  output logic             enc_valid_out,
  output logic [4:0]       enc_addr_out,
  output logic             match_found_out,
  // Unencoded result
  output logic             unenc_valid_out,
  output logic             unenc_half_out,
  output logic [15:0]      unenc_lines_out
);
  cam_match_pkg::cam_state_e st_r;          // Sequencer state
  logic [1:0]                wr_left_r;     // Write cycles still to run
  logic [4:0]                wr_addr_r;     // Captured write address
  logic [31:0]               wr_data_r;     // Captured write word
  logic [31:0]               wr_care_r;     // Captured care mask
  logic [15:0]               hi_lines_r;    // Upper half held for second cycle
  logic [31:0]               hits;          // Per-word compare result
  logic                      accept_wr;     // Write taken this cycle
  logic                      accept_srch;   // Search taken this cycle
  logic                      commit;        // Last write cycle, word lands

  // Lowest matching index wins; duplicates are the reader's concern
  function automatic logic [4:0] first_hit(input logic [31:0] v);
    logic [4:0] idx;
    idx = cam_match_pkg::ADDR_RST;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Word select shared by every cell
  function automatic logic word_sel(input logic [4:0] addr, input int unsigned idx);
    return addr == 5'(idx);
  endfunction

  // Writes take priority; nothing is taken while busy
  // Refused requests leave no trace, so the requester must watch busy_out
  assign accept_wr   = (st_r == cam_match_pkg::ST_IDLE) && wr_req_in;
  assign accept_srch = (st_r == cam_match_pkg::ST_IDLE) && !wr_req_in && search_req_in;
  assign commit      = (st_r == cam_match_pkg::ST_WRITE) && (wr_left_r == 2'h1);

  // One cell per stored word
  for (genvar g = 0; g < cam_match_pkg::WORDS; g++) begin : gen_word
    cam_word_cell #(
      .init_data  (init_data[g]),
      .init_care  (init_care[g]),
      .init_valid (init_valid[g])
    ) u_cell (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .write_in  (commit && word_sel(wr_addr_r, g)),
      .wdata_in  (wr_data_r),
      .wcare_in  (wr_care_r),
      .search_in (search_data_in),
      .match_out (hits[g])
    );
  end

  // Write capture; plain writes store a full care mask
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_addr_r <= cam_match_pkg::ADDR_RST;
      wr_data_r <= cam_match_pkg::DATA_RST;
      wr_care_r <= cam_match_pkg::CARE_ALL;
    end else if (accept_wr) begin
      wr_addr_r <= wr_addr_in;
      wr_data_r <= wr_data_in;
      wr_care_r <= wr_mask_in ? wr_care_in : cam_match_pkg::CARE_ALL;
    end
  end

  // Sequencer: write occupancy and second unencoded cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r      <= cam_match_pkg::ST_IDLE;
      wr_left_r <= 2'h0;
      busy_out  <= 1'b0;
    end else begin
      case (st_r)
        cam_match_pkg::ST_IDLE: begin
          if (accept_wr) begin
            // Masked writes need one extra cycle
            wr_left_r <= wr_mask_in ? cam_match_pkg::WR_LEFT_MASK : cam_match_pkg::WR_LEFT_PLAIN;
            st_r      <= cam_match_pkg::ST_WRITE;
            busy_out  <= 1'b1;
          end else if (accept_srch && !encoded_in) begin
            st_r     <= cam_match_pkg::ST_UNENC_HI;
            busy_out <= 1'b1;
          end
        end
        cam_match_pkg::ST_WRITE: begin
          // Count down; the word lands in the cycle with one left
          wr_left_r <= wr_left_r - 2'h1;
          if (commit) begin
            st_r     <= cam_match_pkg::ST_IDLE;
            busy_out <= 1'b0;
          end
        end
        cam_match_pkg::ST_UNENC_HI: begin
          // Upper half goes out now, then free for the next request
          st_r     <= cam_match_pkg::ST_IDLE;
          busy_out <= 1'b0;
        end
        default: begin
          st_r     <= cam_match_pkg::ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Encoded result, one-cycle valid; address stands until next encoded search
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enc_valid_out   <= 1'b0;
      enc_addr_out    <= cam_match_pkg::ADDR_RST;
      match_found_out <= 1'b0;
    end else begin
      enc_valid_out <= accept_srch && encoded_in;
      if (accept_srch && encoded_in) begin
        enc_addr_out    <= first_hit(hits);
        match_found_out <= |hits;
      end
    end
  end

  // Unencoded result: low half now, upper half next cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unenc_valid_out <= 1'b0;
      unenc_half_out  <= 1'b0;
      unenc_lines_out <= cam_match_pkg::LINES_RST;
      hi_lines_r      <= cam_match_pkg::LINES_RST;
    end else if (accept_srch && !encoded_in) begin
      unenc_valid_out <= 1'b1;
      unenc_half_out  <= 1'b0;
      unenc_lines_out <= hits[15:0];
      hi_lines_r      <= hits[31:16];
    end else if (st_r == cam_match_pkg::ST_UNENC_HI) begin
      unenc_valid_out <= 1'b1;
      unenc_half_out  <= 1'b1;
      unenc_lines_out <= hi_lines_r;
    end else begin
      unenc_valid_out <= 1'b0;
    end
  end

  // Compare snapshot seen only by the checks below
  logic [31:0] hits_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hits_q <= 32'h0000_0000;
    end else begin
      hits_q <= hits;
    end
  end

  enc_addr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enc_valid_out && match_found_out) |-> hits_q[enc_addr_out] && ((hits_q & ((32'h1 << enc_addr_out) - 32'h1)) == 0))
    else $error("encoded address is not the first match");
  found_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enc_valid_out |-> match_found_out == (hits_q != 32'h0000_0000))
    else $error("match found flag wrong");
  two_halves_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (accept_srch && !encoded_in) |=> (unenc_valid_out && !unenc_half_out) ##1 (unenc_valid_out && unenc_half_out)
      ##1 !(unenc_valid_out && unenc_half_out))
    else $error("unencoded result not in two cycles");
  line_level_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (accept_srch && !encoded_in) |=> unenc_lines_out == $past(hits[15:0]))
    else $error("low half lines wrong");
  all_matches_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (accept_srch && !encoded_in) |=> ##1 {unenc_lines_out, $past(unenc_lines_out)} == $past(hits, 2))
    else $error("unencoded vector misses a match");
  plain_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (accept_wr && !wr_mask_in) |=> busy_out ##1 !busy_out)
    else $error("plain write not two cycles");
  mask_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (accept_wr && wr_mask_in) |=> busy_out [*2] ##1 !busy_out)
    else $error("masked write not three cycles");
  busy_block_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    busy_out |-> !accept_wr && !accept_srch)
    else $error("request taken while busy");
  // Encoded pulse only ever follows an encoded accept
  enc_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enc_valid_out |-> $past(accept_srch) && $past(encoded_in))
    else $error("encoded result without a search");
  // Address and word are taken at the accept edge
  wr_capture_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept_wr |=> wr_addr_r == $past(wr_addr_in) && wr_data_r == $past(wr_data_in))
    else $error("write request not captured");
  // Plain writes store a full care mask, masked ones the given mask
  care_capture_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept_wr |=> wr_care_r == ($past(wr_mask_in) ? $past(wr_care_in) : cam_match_pkg::CARE_ALL))
    else $error("care mask not captured");
endmodule

`default_nettype wire

// ===== cam_match_pkg.sv
// Operation
// - Hold 32 words of 32 bits, compare all
// - Don't-care stored bits never block a match
// - Encoded form gives binary address of match
// - Unencoded form shows 32 words over 16 lines
// - Matching word line high, others low
// - Unencoded form shows every matching word
// - Contents preload at configuration or runtime write
// - Plain write takes two cycles, request held
// - Masked write takes three cycles
`default_nettype none

package cam_match_pkg;
  // Array geometry
  localparam int unsigned WORDS  = 32;
  localparam int unsigned WIDTH  = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned LINES  = 16;
  // Remaining busy cycles after the accept cycle of a write
  localparam logic [1:0] WR_LEFT_PLAIN = 2'h1;
  localparam logic [1:0] WR_LEFT_MASK  = 2'h2;
  // Reset values
  localparam logic [WIDTH-1:0]  DATA_RST = 32'h0000_0000;
  localparam logic [WIDTH-1:0]  CARE_ALL = 32'hffff_ffff;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [LINES-1:0]  LINES_RST = 16'h0000;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_UNENC_HI} cam_state_e;
endpackage

// One stored word with its care mask and compare
module cam_word_cell #(
  parameter logic [31:0] init_data  = cam_match_pkg::DATA_RST,
  parameter logic [31:0] init_care  = cam_match_pkg::CARE_ALL,
  parameter logic        init_valid = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Write side
  input  wire logic        write_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [31:0] wcare_in,
  // Search side
  input  wire logic [31:0] search_in,
  output logic             match_out
);
  logic [31:0] data_r;   // Stored word
  logic [31:0] care_r;   // One per bit that takes part in compare
  logic        valid_r;  // Word has ever been loaded

  // Storage; reset value is the configuration preload
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_r  <= init_data;
      care_r  <= init_care;
      valid_r <= init_valid;
    end else if (write_in) begin
      data_r  <= wdata_in;
      care_r  <= wcare_in;
      valid_r <= 1'b1;
    end
  end

  // Masked bits drop out of the compare
  assign match_out = valid_r && (((search_in ^ data_r) & care_r) == 32'h0000_0000);

  word_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    write_in |=> valid_r && data_r == $past(wdata_in) && care_r == $past(wcare_in))
    else $error("written word not stored");
  mask_ignore_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (valid_r && ((search_in | ~care_r) == (data_r | ~care_r))) |-> match_out)
    else $error("masked bit blocked a match");
  hold_contents_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !write_in |=> $stable(data_r) && $stable(care_r))
    else $error("contents changed without a write");
endmodule

`default_nettype wire

// ===== cam_user_model.sv
`default_nettype none
// Stands in for user logic that writes words and runs searches
module cam_user_model (
  // Clock and status
  input  wire logic        clk_in,
  input  wire logic        busy_in,
  // Results from the block
  input  wire logic        enc_valid_in,
  input  wire logic [4:0]  enc_addr_in,
  input  wire logic        found_in,
  input  wire logic        unenc_valid_in,
  input  wire logic        unenc_half_in,
  input  wire logic [15:0] lines_in,
  // Requests to the block
  output logic             wr_req_out,
  output logic [4:0]       wr_addr_out,
  output logic [31:0]      wr_data_out,
  output logic [31:0]      wr_care_out,
  output logic             wr_mask_out,
  output logic             search_req_out,
  output logic [31:0]      search_data_out,
  output logic             encoded_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle requests at time zero
  initial begin
    {wr_req_out, wr_addr_out, wr_data_out, wr_care_out, wr_mask_out} = '0;
    {search_req_out, search_data_out, encoded_out} = '0;
  end

  // Word write, request held for the whole write time; busy watched each cycle
  task automatic write_word(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c, input logic m,
                            output logic ok);
    @(posedge clk_in);
    wr_req_out  <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    wr_care_out <= c;
    wr_mask_out <= m;
    @(posedge clk_in);
    #1;
    // Taken at the last edge, so the block reports busy now
    ok = busy_in;
    if (m) begin
      @(posedge clk_in);
      #1;
      // Masked write keeps the block busy one cycle more
      ok &= busy_in;
    end
    @(posedge clk_in);
    wr_req_out  <= 1'b0;
    // Released data lines never show the stale word
    wr_data_out <= ~d;
    #1;
    // Free again once the write time is over
    ok &= ~busy_in;
  endtask

  // One search; the unencoded vector is gathered over two cycles
  task automatic search(input logic [31:0] s, input logic enc, output logic ok, output logic [4:0] a,
                        output logic f, output logic [31:0] v);
    @(posedge clk_in);
    search_req_out  <= 1'b1;
    search_data_out <= s;
    encoded_out     <= enc;
    @(posedge clk_in);
    search_req_out  <= 1'b0;
    search_data_out <= ~s;
    #1;
    ok = enc ? enc_valid_in : (unenc_valid_in & ~unenc_half_in);
    a = enc_addr_in;
    f = found_in;
    v[15:0] = lines_in;
    @(posedge clk_in);
    #1;
    // Encoded pulse must be gone, unencoded shows upper half
    ok &= enc ? ~enc_valid_in : (unenc_valid_in & unenc_half_in);
    v[31:16] = lines_in;
  endtask
endmodule
`default_nettype wire

// ===== tb_cam_match_block.sv
`default_nettype none
module tb_cam_match_block;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] PRE_WORD = 32'h5a3c_0f96;
  // Wiring
  logic        clk_in, resetn_in, wr_req, wr_mask, search_req, encoded, busy;
  logic        enc_valid, found, unenc_valid, unenc_half;
  logic [4:0]  wr_addr, enc_addr;
  logic [31:0] wr_data, wr_care, search_data, d, c;
  logic [15:0] lines;
  // Reference model of stored words
  logic [31:0] m_data [32];
  logic [31:0] m_care [32];
  logic [31:0] m_valid;
  integer      seed = 10473, n_mismatch = 0, checks = 0, i, j;

  cam_match_block #(.init_data('{31: PRE_WORD, default: 32'h0000_0000}), .init_valid(32'h8000_0000)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .wr_req_in(wr_req), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .wr_care_in(wr_care), .wr_mask_in(wr_mask), .search_req_in(search_req),
    .search_data_in(search_data), .encoded_in(encoded), .busy_out(busy), .enc_valid_out(enc_valid),
    .enc_addr_out(enc_addr), .match_found_out(found), .unenc_valid_out(unenc_valid),
    .unenc_half_out(unenc_half), .unenc_lines_out(lines));

  cam_user_model u_user (
    .clk_in(clk_in), .busy_in(busy), .enc_valid_in(enc_valid), .enc_addr_in(enc_addr), .found_in(found),
    .unenc_valid_in(unenc_valid), .unenc_half_in(unenc_half), .lines_in(lines), .wr_req_out(wr_req),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_care_out(wr_care), .wr_mask_out(wr_mask),
    .search_req_out(search_req), .search_data_out(search_data), .encoded_out(encoded));

  // Free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write through the partner and mirror it in the model
  task automatic wr(input logic [4:0] a, input logic [31:0] dd, input logic [31:0] cc, input logic m);
    logic ok;
    u_user.write_word(a, dd, cc, m, ok);
    cmp({31'h0, ok}, 32'h1);
    m_data[a] = dd;
    m_care[a] = m ? cc : 32'hffff_ffff;
    m_valid[a] = 1'b1;
  endtask

  // Unencoded form, and encoded form unless dup, against the model; lowest index wins
  task automatic check_search(input logic [31:0] s, input logic dup);
    logic [31:0] ev, v;
    logic [4:0]  ea, a;
    logic        ef, f, ok;
    ev = '0;
    ea = '0;
    ef = 1'b0;
    for (int k = 31; k >= 0; k--) begin
      if (m_valid[k] && ((m_data[k] ^ s) & m_care[k]) == 32'h0) begin
        ev[k] = 1'b1;
        ea = k[4:0];
        ef = 1'b1;
      end
    end
    u_user.search(s, 1'b0, ok, a, f, v);
    cmp({31'h0, ok}, 32'h1);
    cmp(v, ev);
    // Encoded form only trusted without duplicates
    if (!dup) begin
      u_user.search(s, 1'b1, ok, a, f, v);
      cmp({31'h0, ok}, 32'h1);
      cmp({26'h0, a, f}, {26'h0, ea, ef});
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up;
  end

  // Main sequence
  initial begin
    resetn_in = 1'b0;
    for (i = 0; i < 32; i++) begin
      m_data[i] = 32'h0;
      m_care[i] = 32'hffff_ffff;
    end
    m_valid = 32'h8000_0000;
    m_data[31] = PRE_WORD;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    check_search(PRE_WORD, 1'b0);
    check_search(~PRE_WORD, 1'b0);
    $display("test preload done");
    for (i = 0; i < 32; i++) wr(i[4:0], $random(seed), 32'hffff_ffff, 1'b0);
    for (i = 0; i < 10; i++) begin
      j = $random(seed) & 31;
      check_search(m_data[j], 1'b0);
    end
    check_search($random(seed), 1'b0);
    $display("test fill done");
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      c = $random(seed);
      wr(5'(i * 8 + 2), d, c, 1'b1);
      check_search(d ^ ~c, 1'b0);
      check_search(d ^ (c & -c), 1'b0);
    end
    $display("test mask done");
    d = $random(seed);
    wr(5'h07, d, 32'hffff_ffff, 1'b0);
    wr(5'h14, d, 32'hffff_ffff, 1'b0);
    check_search(d, 1'b1);
    $display("test duplicate done");
    wrap_up;
  end
endmodule
`default_nettype wire
